// ### dv/rsc_reset_ctrl_sva.sv
`timescale 1ns/1ps
module rsc_reset_ctrl_sva
  import rsc_pkg::*;
#(
  parameter int SOFT_CYCLES   = 25,
  parameter int FILTER_CYCLES = 25
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [2:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic       avs_waitrequest,
  input wire logic       low_supply,
  input wire logic       sleep_mode,
  input wire logic       watchdog_timeout,
  input wire logic       halt_enter,
  input wire logic       clear_watchdog,
  input wire logic       device_reset,
  input wire logic       pc_sp_clear,
  input wire logic       port_preset,
  input wire logic [1:0] brownout_threshold,
  input wire logic       brownout_enable
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic       wr_ok;
  logic       rd_ok;
  logic [2:0] thr;
  localparam int SOFT_LIM = SOFT_CYCLES + 8;
  localparam int FILT_LIM = FILTER_CYCLES + 4;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest;
  always_comb begin
    case (avs_writedata)
      LVL_2V10: thr = 3'h4;
      LVL_2V55: thr = 3'h5;
      LVL_3V15: thr = 3'h6;
      LVL_3V80: thr = 3'h7;
      default:  thr = 3'h0;
    endcase
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_detector_mode: assert property (brownout_enable == !sleep_mode)
    else $error("detector enable does not follow mode");
  a_level_map: assert property (wr_ok && avs_address == ADDR_LEVEL && thr[2]
    |=> brownout_threshold == $past(thr[1:0]))
    else $error("threshold does not match level code");
  a_flash_reset: assert property (wr_ok && avs_address == ADDR_FLASH1 && avs_writedata == FLASH_RESET
    |-> ##[1:4] device_reset)
    else $error("flash control write gave no reset");
  a_pulse_width: assert property ($rose(device_reset) |-> device_reset[*4] ##1 !device_reset)
    else $error("reset pulse width wrong");
  a_guard_delay: assert property (wr_ok && avs_address == ADDR_GUARD && avs_writedata != GUARD_KEY_A
    && avs_writedata != GUARD_KEY_B |=> !device_reset[*2] ##[1:SOFT_LIM] device_reset)
    else $error("bad guard value reset timing wrong");
  a_level_bad: assert property (wr_ok && avs_address == ADDR_LEVEL && !thr[2]
    |-> ##[1:SOFT_LIM] device_reset)
    else $error("bad level code gave no reset");
  a_wd_awake: assert property (watchdog_timeout && !sleep_mode |-> ##[1:4] device_reset)
    else $error("awake expiry gave no reset");
  a_wd_sleep: assert property (watchdog_timeout && sleep_mode |-> ##[1:2] pc_sp_clear)
    else $error("sleep expiry gave no counter clear");
  a_pcsp_single: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("counter clear longer than one cycle");
  a_cause_upper: assert property (rd_ok && avs_address == ADDR_CAUSE |-> avs_readdata[7:4] == 4'h0)
    else $error("cause upper bits not zero");
  a_brown_reset: assert property ((low_supply && !sleep_mode)[*8] |-> ##[0:FILT_LIM] device_reset)
    else $error("long low supply gave no reset");
endmodule // rsc_reset_ctrl_sva

bind rsc_reset_ctrl rsc_reset_ctrl_sva #(.SOFT_CYCLES(SOFT_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) u_sva (
  .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_supply(low_supply), .sleep_mode(sleep_mode), .watchdog_timeout(watchdog_timeout),
  .halt_enter(halt_enter), .clear_watchdog(clear_watchdog), .device_reset(device_reset),
  .pc_sp_clear(pc_sp_clear), .port_preset(port_preset), .brownout_threshold(brownout_threshold),
  .brownout_enable(brownout_enable));

// ### dv/rsc_reset_ctrl_tb.sv
`timescale 1ns/1ps
module rsc_reset_ctrl_tb;
  import rsc_pkg::*;
  logic       mclk, nrst, avs_read, avs_write, avs_waitrequest, low_supply, sleep_mode;
  logic       watchdog_timeout, halt_enter, clear_watchdog, device_reset, pc_sp_clear, port_preset;
  logic       brownout_enable;
  logic [1:0] brownout_threshold;
  logic [2:0] avs_address;
  logic [7:0] avs_writedata, avs_readdata, q;
  logic [7:0] lv [4];
  int         n_fail, n_tests, i;

  // Short counts keep the bad-key and filter waits brief.
  rsc_reset_ctrl #(.SOFT_CYCLES(4), .FILTER_CYCLES(4)) dut (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .low_supply(low_supply), .sleep_mode(sleep_mode), .watchdog_timeout(watchdog_timeout),
    .halt_enter(halt_enter), .clear_watchdog(clear_watchdog), .device_reset(device_reset),
    .pc_sp_clear(pc_sp_clear), .port_preset(port_preset), .brownout_threshold(brownout_threshold),
    .brownout_enable(brownout_enable));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge at which the slave accepts the request.
  task automatic acc(input logic we, input logic [2:0] a, input logic [7:0] d, output logic [7:0] r);
    logic w;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !we;
    avs_write     <= we;
    w = 1'b1;
    for (int k = 0; k < 20 && w; k++) begin
      @(posedge mclk);
      w = avs_waitrequest;
      r = avs_readdata;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (w) begin
      chk(8'h01, 8'h00);
      test_done();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask

  task automatic wrst();
    int k;
    for (k = 0; k < 60 && device_reset !== 1'b1; k++) @(posedge mclk);
    chk({7'h00, device_reset}, 8'h01);
    if (device_reset !== 1'b1) test_done();
    @(posedge mclk);
    low_supply <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic quiet(input int n, input logic exp_clr);
    logic sr, sc;
    sr = 1'b0;
    sc = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      sr = sr | device_reset;
      sc = sc | pc_sp_clear;
    end
    chk({6'h00, sc, sr}, {6'h00, exp_clr, 1'b0});
  endtask

  task automatic pulse(input int s);
    @(posedge mclk);
    if (s == 0) watchdog_timeout <= 1'b1;
    if (s == 1) halt_enter <= 1'b1;
    if (s == 2) clear_watchdog <= 1'b1;
    @(posedge mclk);
    {watchdog_timeout, halt_enter, clear_watchdog} <= 3'h0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {nrst, avs_read, avs_write, low_supply, sleep_mode, watchdog_timeout, halt_enter, clear_watchdog} = '0;
    avs_address = 3'h0;
    avs_writedata = 8'h00;
    n_fail = 0;
    n_tests = 0;
    lv = '{LVL_2V10, LVL_2V55, LVL_3V15, LVL_3V80};
    repeat (5) @(posedge mclk);
    chk({5'h00, pc_sp_clear, port_preset, device_reset}, 8'h03);
    nrst <= 1'b1;
    rdc(ADDR_GUARD, GUARD_POR);
    rdc(ADDR_LEVEL, LEVEL_POR);
    rdc(ADDR_CTRL, 8'h00);
    wr(ADDR_CAUSE, 8'h00);
    rdc(ADDR_CAUSE, 8'h00);
    rdc(3'h7, 8'h00);
    rdc(ADDR_FLASH1, 8'h00);
    @(posedge mclk);
    chk({7'h00, brownout_enable}, 8'h01);
    sleep_mode <= 1'b1;
    low_supply <= 1'b1;
    @(posedge mclk);
    chk({7'h00, brownout_enable}, 8'h00);
    quiet(12, 1'b0);
    low_supply <= 1'b0;
    quiet(6, 1'b0);
    sleep_mode <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_LEVEL, lv[i]);
      @(posedge mclk);
      chk({6'h00, brownout_threshold}, i[7:0]);
      rdc(ADDR_LEVEL, lv[i]);
    end
    pulse(1);
    sleep_mode <= 1'b1;
    pulse(0);
    quiet(12, 1'b1);
    sleep_mode <= 1'b0;
    rdc(ADDR_CTRL, 8'h03);
    @(posedge mclk);
    low_supply <= 1'b1;
    repeat (2) @(posedge mclk);
    low_supply <= 1'b0;
    quiet(12, 1'b0);
    low_supply <= 1'b1;
    wrst();
    rdc(ADDR_CAUSE, 8'h04);
    rdc(ADDR_LEVEL, LVL_3V80);
    rdc(ADDR_CTRL, 8'h03);
    pulse(2);
    rdc(ADDR_CTRL, 8'h00);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_GUARD, GUARD_KEY_B);
    quiet(12, 1'b0);
    wr(ADDR_GUARD, 8'h12);
    wrst();
    rdc(ADDR_CAUSE, 8'h08);
    wr(ADDR_CAUSE, 8'hFF);
    rdc(ADDR_CAUSE, 8'h08);
    rdc(ADDR_GUARD, GUARD_POR);
    wr(ADDR_CAUSE, 8'h00);
    rdc(ADDR_CAUSE, 8'h00);
    wr(ADDR_LEVEL, 8'h00);
    wrst();
    rdc(ADDR_CAUSE, 8'h02);
    rdc(ADDR_LEVEL, LEVEL_POR);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_WDKEY, 8'h18);
    wrst();
    rdc(ADDR_CAUSE, 8'h01);
    rdc(ADDR_WDKEY, {WDKEY_POR, 3'h0});
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_FLASH1, 8'h54);
    quiet(12, 1'b0);
    wr(ADDR_FLASH1, FLASH_RESET);
    wrst();
    pulse(0);
    wrst();
    rdc(ADDR_CTRL, 8'h01);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    rdc(ADDR_CTRL, 8'h00);
    test_done();
  end
endmodule // rsc_reset_ctrl_tb

// ### verilog/rsc_cnt_if.sv
`timescale 1ns/1ps
interface rsc_cnt_if;
  logic       start;
  logic       clear;
  logic       done;
  modport owner (output start, output clear, input done);
  modport timer (input start, input clear, output done);
endinterface

// ### verilog/rsc_pkg.sv
package rsc_pkg;

  // ****************************************************************
  // Register map and key values
  // ****************************************************************
  localparam logic [2:0] ADDR_GUARD   = 3'h0;
  localparam logic [2:0] ADDR_CAUSE   = 3'h1;
  localparam logic [2:0] ADDR_LEVEL   = 3'h2;
  localparam logic [2:0] ADDR_CTRL    = 3'h3;
  localparam logic [2:0] ADDR_FLASH1  = 3'h4;
  localparam logic [2:0] ADDR_WDKEY   = 3'h5;

  localparam logic [7:0] GUARD_KEY_A  = 8'h55;
  localparam logic [7:0] GUARD_KEY_B  = 8'hAA;
  localparam logic [7:0] GUARD_POR    = 8'h55;
  localparam logic [7:0] LVL_2V10     = 8'h55;
  localparam logic [7:0] LVL_2V55     = 8'h33;
  localparam logic [7:0] LVL_3V15     = 8'h99;
  localparam logic [7:0] LVL_3V80     = 8'hAA;
  localparam logic [7:0] LEVEL_POR    = 8'h55;
  localparam logic [7:0] FLASH_RESET  = 8'h55;
  localparam logic [4:0] WDKEY_A      = 5'h15;
  localparam logic [4:0] WDKEY_B      = 5'h0A;
  localparam logic [4:0] WDKEY_POR    = 5'h0A;

  localparam int CAUSE_WD_KEY = 0;
  localparam int CAUSE_LEVEL  = 1;
  localparam int CAUSE_BROWN  = 2;
  localparam int CAUSE_GUARD  = 3;
  localparam int CTRL_TO      = 0;
  localparam int CTRL_PDF     = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ           = 25000000;
  localparam int SOFT_DELAY_NS    = 1000;
  localparam int BROWN_FILTER_NS  = 1000;
  localparam int SOFT_DELAY_CYC   = (SOFT_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BROWN_FILTER_CYC = (BROWN_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RESET_PULSE_CYC  = 4;

  typedef enum logic [1:0] {
    RSC_RUN  = 2'b00,
    RSC_WAIT = 2'b01,
    RSC_HOLD = 2'b10
  } rsc_state_type;

endpackage

// ### verilog/rsc_reset_ctrl.sv
`timescale 1ns/1ps
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int SOFT_CYCLES   = SOFT_DELAY_CYC,
  parameter int FILTER_CYCLES = BROWN_FILTER_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [2:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic      [7:0] avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic       low_supply,
  input  wire logic       sleep_mode,
  input  wire logic       watchdog_timeout,
  input  wire logic       halt_enter,
  input  wire logic       clear_watchdog,
  output logic            device_reset,
  output logic            pc_sp_clear,
  output logic            port_preset,
  output logic      [1:0] brownout_threshold,
  output logic            brownout_enable
);

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  logic [7:0]    reset_guard_key_r;
  logic [7:0]    brownout_level_key_r;
  logic [4:0]    watchdog_key_field_r;
  logic [3:0]    reset_cause_flags_r;
  logic          watchdog_expiry_flag_r;
  logic          powerdown_flag_r;
  logic          ack_r;
  logic          por_done_r;
  logic [2:0]    sup_sync_r;
  logic          sup_low_r;
  rsc_state_type state_r;
  rsc_state_type state_nxt;
  logic [2:0]    hold_r;
  logic          brown_pend_r;
  logic          level_pend_r;
  logic          guard_pend_r;
  logic          wdkey_pend_r;
  logic          flash_hit;
  logic          wd_run_hit;
  logic          wr;
  logic          guard_bad;
  logic          level_bad;
  logic          wdkey_bad;
  logic          soft_bad;
  logic          brown_fire;
  logic          soft_fire;
  logic          fire;
  logic          guard_wr;
  logic          level_wr;
  logic          wdkey_wr;
  logic          cause_wr;

  rsc_cnt_if soft_if ();
  rsc_cnt_if filt_if ();

  function automatic logic level_ok(input logic [7:0] v);
    level_ok = (v == LVL_2V10) || (v == LVL_2V55) || (v == LVL_3V15) || (v == LVL_3V80);
  endfunction

  function automatic logic reg_wr(input logic we, input logic [2:0] a, input logic [2:0] idx);
    reg_wr = we && (a == idx);
  endfunction

  // Waitrequest drops one cycle after the request, so every access takes two edges.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr              = avs_write && ack_r;
  assign guard_wr        = reg_wr(wr, avs_address, ADDR_GUARD);
  assign level_wr        = reg_wr(wr, avs_address, ADDR_LEVEL);
  assign wdkey_wr        = reg_wr(wr, avs_address, ADDR_WDKEY);
  assign cause_wr        = reg_wr(wr, avs_address, ADDR_CAUSE);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 8'h00;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        ADDR_GUARD: avs_readdata <= reset_guard_key_r;
        ADDR_CAUSE: avs_readdata <= {4'h0, reset_cause_flags_r};
        ADDR_LEVEL: avs_readdata <= brownout_level_key_r;
        ADDR_CTRL:  avs_readdata <= {6'h00, powerdown_flag_r, watchdog_expiry_flag_r};
        ADDR_WDKEY: avs_readdata <= {watchdog_key_field_r, 3'h0};
        default:    avs_readdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Power-on marker and supply input synchroniser
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      por_done_r <= 1'b0;
    end else begin
      por_done_r <= 1'b1;
    end
  end
  assign port_preset = !por_done_r;

  // The first stage feeds only the second; a change counts when stages two and three agree.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sup_sync_r <= 3'h0;
      sup_low_r  <= 1'b0;
    end else begin
      sup_sync_r <= {sup_sync_r[1:0], low_supply};
      if (sup_sync_r[1] == sup_sync_r[2]) begin
        sup_low_r <= sup_sync_r[2];
      end
    end
  end

  // ****************************************************************
  // Key checks and timers
  // ****************************************************************
  assign brownout_enable = !sleep_mode;
  assign guard_bad = (reset_guard_key_r != GUARD_KEY_A) && (reset_guard_key_r != GUARD_KEY_B);
  assign level_bad = !level_ok(brownout_level_key_r);
  assign wdkey_bad = (watchdog_key_field_r != WDKEY_A) && (watchdog_key_field_r != WDKEY_B);
  assign soft_bad  = guard_bad || level_bad || wdkey_bad;

  always_comb begin
    case (brownout_level_key_r)
      LVL_2V55: brownout_threshold = 2'h1;
      LVL_3V15: brownout_threshold = 2'h2;
      LVL_3V80: brownout_threshold = 2'h3;
      default:  brownout_threshold = 2'h0;
    endcase
  end

  // A glitch shorter than the filter restarts the count and never fires.
  assign filt_if.start = sup_low_r && brownout_enable;
  assign filt_if.clear = (state_r != RSC_RUN);
  assign soft_if.start = soft_bad;
  assign soft_if.clear = (state_r != RSC_RUN);

  rsc_timer #(.COUNT(FILTER_CYCLES)) u_filter (.mclk(mclk), .nrst(nrst), .cnt(filt_if));
  rsc_timer #(.COUNT(SOFT_CYCLES))   u_soft   (.mclk(mclk), .nrst(nrst), .cnt(soft_if));

  assign brown_fire = filt_if.done;
  assign soft_fire  = soft_if.done;
  assign flash_hit  = reg_wr(wr, avs_address, ADDR_FLASH1) && (avs_writedata == FLASH_RESET);
  assign wd_run_hit = watchdog_timeout && !sleep_mode;
  assign fire       = brown_fire || soft_fire || flash_hit || wd_run_hit;

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSC_RUN: begin
        if (fire) begin
          state_nxt = RSC_HOLD;
        end
      end
      RSC_HOLD: begin
        if (hold_r == 3'(RESET_PULSE_CYC - 1)) begin
          state_nxt = RSC_WAIT;
        end
      end
      RSC_WAIT: begin
        state_nxt = RSC_RUN;
      end
      default: begin
        state_nxt = RSC_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= 3'h0;
    end else begin
      hold_r <= (state_r == RSC_HOLD) ? hold_r + 3'h1 : 3'h0;
    end
  end

  // Full resets of every cause drive the same output, so they reach the same state.
  assign device_reset = !por_done_r || (state_r == RSC_HOLD);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pc_sp_clear <= 1'b0;
    end else begin
      pc_sp_clear <= watchdog_timeout && sleep_mode;
    end
  end

  // Causes are latched on the firing edge so the flags set one cycle after the pulse starts.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      brown_pend_r <= 1'b0;
    end else begin
      brown_pend_r <= (state_r == RSC_RUN) && brown_fire;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      level_pend_r <= 1'b0;
    end else begin
      level_pend_r <= (state_r == RSC_RUN) && soft_fire && level_bad;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      guard_pend_r <= 1'b0;
    end else begin
      guard_pend_r <= (state_r == RSC_RUN) && soft_fire && guard_bad;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdkey_pend_r <= 1'b0;
    end else begin
      wdkey_pend_r <= (state_r == RSC_RUN) && soft_fire && wdkey_bad;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reset_guard_key_r <= GUARD_POR;
    end else if (guard_pend_r) begin
      reset_guard_key_r <= GUARD_POR;
    end else if (guard_wr) begin
      reset_guard_key_r <= avs_writedata;
    end
  end

  // A brownout reset leaves the level register alone; only a bad code restores it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      brownout_level_key_r <= LEVEL_POR;
    end else if (level_pend_r) begin
      brownout_level_key_r <= LEVEL_POR;
    end else if (level_wr) begin
      brownout_level_key_r <= avs_writedata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      watchdog_key_field_r <= WDKEY_POR;
    end else if (wdkey_pend_r) begin
      watchdog_key_field_r <= WDKEY_POR;
    end else if (wdkey_wr) begin
      watchdog_key_field_r <= avs_writedata[7:3];
    end
  end

  // ****************************************************************
  // Reset cause flags
  // ****************************************************************
  // Hardware set wins over a same-cycle software clear; software may only write zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reset_cause_flags_r <= 4'h0;
    end else begin
      if (cause_wr) begin
        reset_cause_flags_r <= reset_cause_flags_r & avs_writedata[3:0];
      end
      if (guard_pend_r) begin
        reset_cause_flags_r[CAUSE_GUARD] <= 1'b1;
      end
      if (brown_pend_r) begin
        reset_cause_flags_r[CAUSE_BROWN] <= 1'b1;
      end
      if (level_pend_r) begin
        reset_cause_flags_r[CAUSE_LEVEL] <= 1'b1;
      end
      if (wdkey_pend_r) begin
        reset_cause_flags_r[CAUSE_WD_KEY] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      watchdog_expiry_flag_r <= 1'b0;
    end else if (watchdog_timeout) begin
      watchdog_expiry_flag_r <= 1'b1;
    end else if (clear_watchdog || halt_enter) begin
      watchdog_expiry_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      powerdown_flag_r <= 1'b0;
    end else if (halt_enter) begin
      powerdown_flag_r <= 1'b1;
    end else if (clear_watchdog) begin
      powerdown_flag_r <= 1'b0;
    end
  end

endmodule // rsc_reset_ctrl

// ### verilog/rsc_timer.sv
`timescale 1ns/1ps
module rsc_timer
  import rsc_pkg::*;
#(
  parameter int COUNT = 25
) (
  input wire logic mclk,
  input wire logic nrst,
  rsc_cnt_if.timer cnt
);

  // ****************************************************************
  // Counts COUNT cycles of a held start, then holds done.
  // ****************************************************************
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (cnt.clear || !cnt.start) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(COUNT)) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign cnt.done = cnt.start && !cnt.clear && (cnt_r == W'(COUNT));

endmodule // rsc_timer
